// ### pvp_cfg.svh
/*
 * Constants of the parallel video port: register offsets, control field
 * positions, status bit positions, reset values and synchroniser depth.
 * Assumes inclusion by bare name from the package and the design module.
 */
`ifndef PVP_CFG_SVH
`define PVP_CFG_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define PVP_OFS_CTRL 8'h00
`define PVP_OFS_DELAY 8'h04
`define PVP_OFS_COUNT 8'h08
`define PVP_OFS_STATUS 8'h0C
`define PVP_OFS_RXDATA 8'h10
`define PVP_OFS_TXDATA 8'h14
`define PVP_OFS_LINE_LEN 8'h18
`define PVP_OFS_FRAME_LINES 8'h1C

// ------------------------------------------------------------------
// Control fields
// ------------------------------------------------------------------
`define PVP_CTRL_EN 0
`define PVP_CTRL_ITU 1
`define PVP_CTRL_GPMODE_LO 2
`define PVP_CTRL_ITUMODE_LO 4
`define PVP_CTRL_ITUOUT 6
`define PVP_CTRL_WIDTH_LO 8
`define PVP_CTRL_NFS_LO 12

// ------------------------------------------------------------------
// Status bits
// ------------------------------------------------------------------
`define PVP_ST_RXV 0
`define PVP_ST_OVR 1
`define PVP_ST_TXF 2
`define PVP_ST_UND 3
`define PVP_ST_ACT 4
`define PVP_ST_VBL 5
`define PVP_ST_FLD 6
`define PVP_ST_SYNC 7
`define PVP_ST_CFGERR 8
`define PVP_ST_PHASE_LO 9

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define PVP_RST_CTRL 16'h1F00
`define PVP_RST_DELAY 16'h0000
`define PVP_RST_COUNT 16'h0001
`define PVP_RST_LINE_LEN 16'h0010
`define PVP_RST_FRAME_LINES 16'h0004

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define PVP_SYNC_STAGES 3

`endif

// ### pvp_pkg.sv
/*
 * Types of the parallel video port: modes, transfer phase, pin carrier and
 * the module's whole state record.
 * Assumes pvp_cfg.svh is on the include path.
 */
`include "pvp_cfg.svh"

package pvp_pkg;

    typedef enum logic [1:0] {PVP_GP_IN = 2'b00, PVP_GP_CAP = 2'b01, PVP_GP_OUT = 2'b10} pvp_gp_e;
    typedef enum logic [1:0] {PVP_ITU_ACT = 2'b00, PVP_ITU_VBI = 2'b01, PVP_ITU_FIELD = 2'b10} pvp_itu_e;
    typedef enum logic [1:0] {PVP_PH_IDLE = 2'b00, PVP_PH_DELAY = 2'b01, PVP_PH_XFER = 2'b10} pvp_phase_e;

    typedef struct packed {
        logic [2:0] fs_out;
        logic [2:0] fs_oe;
        logic [15:0] data_out;
        logic [15:0] data_oe;
    } pvp_pins_s;

    typedef struct packed {
        logic [15:0] ctrl, delay, count, line_len, frame_lines;
        logic [15:0] rxd, txd;
        logic rx_valid, overrun, tx_full, underrun;
        logic [2:0] clk_s;
        logic clk_f;
        logic [2:0] fs_s0, fs_s1, fs_s2, fs_f;
        logic [15:0] dat_s0, dat_s1, dat_s2;
        pvp_phase_e phase;
        logic [15:0] cnt, hcnt, vcnt, lines;
        logic [2:0] fs_drv;
        logic [15:0] dout;
        logic [1:0] pre;
        logic fld, vbl, act, synced;
        logic [2:0][15:0] dl_d;
        logic [2:0] dl_p;
        logic [31:0] prdata;
        logic pslverr;
    } pvp_state_s;

endpackage : pvp_pkg

// ### pvp_port.sv
/*
 * Parallel video port with an APB register slave. General-purpose input,
 * frame capture and output submodes, and 656 active-video, blanking and
 * entire-field submodes with embedded timing reference decoding.
 * Assumes the port clock, frame syncs and data pins are asynchronous to
 * ref_clk and that the port clock runs well below ref_clk.
 */
`include "pvp_cfg.svh"

//Contract
// - One external port clock input, three frame sync lines, sixteen data lines.
// - Port clock stays at or below half the system clock rate; the synchronisers see it only at a quarter of that rate or below.
// - Each frame sync line is either an input or a driven output.
// - General-purpose transfers go one direction at a time, words up to sixteen bits.
// - 656 transfers carry 8 or 10 bit samples, one direction at a time.
// - 656 input decodes embedded line and field timing preambles.
// - Input submode: frame syncs and data are all inputs.
// - Frame capture: port drives sync one as line sync, two as frame sync.
// - Output submode: port drives data and up to three frame syncs.
// - Input submode: first frame sync from outside starts each read.
// - After the sync, wait the delay setting in port clocks before sampling.
// - Capture exactly the count setting of samples per frame sync.
// - Sample width is 8 bits or 10 through 16 bits.
// - Active-video submode drops samples from end to start of active video and blanking lines.
// - Active-video submode never passes timing reference words on.
// - Active-video submode ignores samples after field start until a start-of-active code.
// - Active-video submode transfers count setting active lines per frame.
// - Blanking submode passes only vertical blanking samples.
// - Entire-field submode passes every sample, references and ancillary data included.
// - Entire-field submode starts right after locking to the first field.
module pvp_port import pvp_pkg::*; #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins
    input wire logic port_clock,
    input wire logic [2:0] frame_sync_in,
    input wire logic [DATA_W-1:0] data_in,
    output pvp_pins_s pins
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DATA_W != 16) begin : g_bad_width
        $error("pvp_port: DATA_W must be 16");
    end
    if (ADDR_W < 5) begin : g_bad_addr
        $error("pvp_port: ADDR_W must be at least 5");
    end

    pvp_state_s q, n;

    // ------------------------------------------------------------------
    // Decoded control
    // ------------------------------------------------------------------
    logic en, itu, itu_out, w10, cfg_err, out_dir;
    pvp_gp_e gpm;
    pvp_itu_e itm;
    logic [3:0] wc;
    logic [1:0] nfs;
    logic [15:0] wmask;

    assign en = q.ctrl[`PVP_CTRL_EN];
    assign itu = q.ctrl[`PVP_CTRL_ITU];
    assign gpm = pvp_gp_e'(q.ctrl[`PVP_CTRL_GPMODE_LO +: 2]);
    assign itm = pvp_itu_e'(q.ctrl[`PVP_CTRL_ITUMODE_LO +: 2]);
    assign itu_out = q.ctrl[`PVP_CTRL_ITUOUT];
    assign wc = q.ctrl[`PVP_CTRL_WIDTH_LO +: 4];
    assign nfs = q.ctrl[`PVP_CTRL_NFS_LO +: 2];
    assign w10 = (wc == 4'h9);
    // 8 bits, or 10..16 bits; 656 only 8 or 10; reserved modes refused
    assign cfg_err = (wc < 4'h7) || (wc == 4'h8) || (itu && (wc != 4'h7) && !w10) ||
                     (!itu && (gpm == 2'b11)) || (itu && (itm == 2'b11));
    assign out_dir = itu ? itu_out : (gpm == PVP_GP_OUT);

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            wmask[i] = (i <= int'(wc));
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic pclk_rise, trig, push, ovr_ev, und_ev, ref_w, pass_in, rd_acc, wr_acc;
    logic [2:0] fs_rise;
    logic [15:0] smp, push_d;
    logic [7:0] s8;
    logic [ADDR_W-1:0] a;

    always_comb begin
        n = q;
        push = 1'b0;
        push_d = 16'h0000;
        ovr_ev = 1'b0;
        und_ev = 1'b0;
        ref_w = 1'b0;
        pass_in = 1'b0;
        trig = 1'b0;
        fs_rise = 3'h0;
        a = paddr;
        rd_acc = psel && penable && !pwrite;
        wr_acc = psel && penable && pwrite;

        // Three-stage synchronisers; a change counts when stages two and three agree
        n.clk_s = {q.clk_s[1:0], port_clock};
        n.fs_s0 = frame_sync_in;
        n.fs_s1 = q.fs_s0;
        n.fs_s2 = q.fs_s1;
        n.dat_s0 = data_in;
        n.dat_s1 = q.dat_s0;
        n.dat_s2 = q.dat_s1;
        if (q.clk_s[1] == q.clk_s[2]) begin
            n.clk_f = q.clk_s[2];
        end
        // Edges closer than two ref_clk cycles are not seen
        pclk_rise = (q.clk_s[1] == q.clk_s[2]) && q.clk_s[2] && !q.clk_f;
        // Sync one settles only at port clock edges, so a rise between edges still triggers
        for (int i = 0; i < 3; i++) begin
            if ((q.fs_s1[i] == q.fs_s2[i]) && ((i != 0) || pclk_rise)) begin
                n.fs_f[i] = q.fs_s2[i];
            end
            fs_rise[i] = (q.fs_s1[i] == q.fs_s2[i]) && q.fs_s2[i] && !q.fs_f[i];
        end
        smp = q.dat_s2 & wmask;
        s8 = w10 ? smp[9:2] : smp[7:0];

        // ------------------------------------------------------------------
        // Port side, one step per port clock rising edge
        // ------------------------------------------------------------------
        if (!en || cfg_err) begin
            n.phase = PVP_PH_IDLE;
            n.cnt = 16'h0000;
            n.hcnt = 16'h0000;
            n.vcnt = 16'h0000;
            n.fs_drv = 3'h0;
            n.synced = 1'b0;
            n.pre = 2'h0;
            n.act = 1'b0;
            n.dl_p = 3'h0;
        end else if (pclk_rise && itu && itu_out) begin
            // 656 output streams the transmit word every port clock
            if (q.tx_full) begin
                n.dout = q.txd & wmask;
                n.tx_full = 1'b0;
            end else begin
                und_ev = 1'b1;
            end
        end else if (pclk_rise && itu) begin
            // Timing reference: FF 00 00 then status word
            case (q.pre)
                2'h0: n.pre = (s8 == 8'hFF) ? 2'h1 : 2'h0;
                2'h1: n.pre = (s8 == 8'h00) ? 2'h2 : ((s8 == 8'hFF) ? 2'h1 : 2'h0);
                2'h2: n.pre = (s8 == 8'h00) ? 2'h3 : ((s8 == 8'hFF) ? 2'h1 : 2'h0);
                2'h3: begin
                    n.pre = 2'h0;
                    ref_w = 1'b1;
                end
                default: n.pre = 2'h0;
            endcase
            case (itm)
                PVP_ITU_FIELD: pass_in = q.synced;
                PVP_ITU_VBI: pass_in = q.synced && q.vbl;
                PVP_ITU_ACT: pass_in = q.synced && q.act && !q.vbl && (q.lines != 16'h0000);
                default: pass_in = 1'b0;
            endcase
            if (ref_w) begin
                n.fld = s8[6];
                n.vbl = s8[5];
                // Field one starts when F falls
                if (!s8[6] && q.fld) begin
                    n.synced = 1'b1;
                    n.lines = 16'h0000;
                end
                if (!s8[4] && !s8[5] && (q.synced || (!s8[6] && q.fld)) &&
                    (q.lines < q.count) && !(q.fld && !s8[6] && 1'b0)) begin
                    n.act = 1'b1;
                    n.lines = ((!s8[6] && q.fld) ? 16'h0000 : q.lines) + 16'h0001;
                end else begin
                    n.act = 1'b0;
                end
                if (itm != PVP_ITU_FIELD) begin
                    pass_in = 1'b0;
                    n.dl_p = 3'h0;
                end
            end
            // Three-word delay so the preamble can be withdrawn once recognised
            n.dl_d = {q.dl_d[1:0], smp};
            if (!(ref_w && (itm != PVP_ITU_FIELD))) begin
                n.dl_p = {q.dl_p[1:0], pass_in};
            end else begin
                n.dl_p = 3'h0;
            end
            if (q.dl_p[2] && !(ref_w && (itm != PVP_ITU_FIELD))) begin
                push = 1'b1;
                push_d = q.dl_d[2];
            end
        end else if (pclk_rise) begin
            // Line and frame timing for the driven syncs
            trig = (q.hcnt == q.line_len - 16'h0001);
            n.hcnt = trig ? 16'h0000 : q.hcnt + 16'h0001;
            if (trig) begin
                n.vcnt = (q.vcnt == q.frame_lines - 16'h0001) ? 16'h0000 : q.vcnt + 16'h0001;
            end
            n.fs_drv[0] = (n.hcnt == 16'h0000);
            n.fs_drv[1] = (n.vcnt == 16'h0000);
            n.fs_drv[2] = (n.vcnt == 16'h0000) && (n.hcnt == 16'h0000);
            if (gpm == PVP_GP_IN) begin
                trig = fs_rise[0];
            end
            case (q.phase)
                PVP_PH_IDLE: begin
                    if (trig && (q.count != 16'h0000)) begin
                        n.phase = (q.delay == 16'h0000) ? PVP_PH_XFER : PVP_PH_DELAY;
                        n.cnt = 16'h0000;
                    end
                end
                PVP_PH_DELAY: begin
                    n.cnt = q.cnt + 16'h0001;
                    if (q.cnt == q.delay - 16'h0001) begin
                        n.phase = PVP_PH_XFER;
                        n.cnt = 16'h0000;
                    end
                end
                PVP_PH_XFER: begin
                    if (gpm == PVP_GP_OUT) begin
                        if (q.tx_full) begin
                            n.dout = q.txd & wmask;
                            n.tx_full = 1'b0;
                        end else begin
                            und_ev = 1'b1;
                        end
                    end else begin
                        push = 1'b1;
                        push_d = smp;
                    end
                    n.cnt = q.cnt + 16'h0001;
                    if (q.cnt == q.count - 16'h0001) begin
                        n.phase = PVP_PH_IDLE;
                        n.cnt = 16'h0000;
                    end
                end
                default: n.phase = PVP_PH_IDLE;
            endcase
        end

        // ------------------------------------------------------------------
        // APB: read data latched in setup, effects at access
        // ------------------------------------------------------------------
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            case (a[4:0])
                5'(`PVP_OFS_CTRL): n.prdata = {16'h0000, q.ctrl};
                5'(`PVP_OFS_DELAY): n.prdata = {16'h0000, q.delay};
                5'(`PVP_OFS_COUNT): n.prdata = {16'h0000, q.count};
                5'(`PVP_OFS_RXDATA): n.prdata = {16'h0000, q.rxd};
                5'(`PVP_OFS_TXDATA): n.prdata = {16'h0000, q.txd};
                5'(`PVP_OFS_LINE_LEN): n.prdata = {16'h0000, q.line_len};
                5'(`PVP_OFS_FRAME_LINES): n.prdata = {16'h0000, q.frame_lines};
                5'(`PVP_OFS_STATUS): begin
                    n.prdata = 32'h0000_0000;
                    n.prdata[`PVP_ST_RXV] = q.rx_valid;
                    n.prdata[`PVP_ST_OVR] = q.overrun;
                    n.prdata[`PVP_ST_TXF] = q.tx_full;
                    n.prdata[`PVP_ST_UND] = q.underrun;
                    n.prdata[`PVP_ST_ACT] = q.act;
                    n.prdata[`PVP_ST_VBL] = q.vbl;
                    n.prdata[`PVP_ST_FLD] = q.fld;
                    n.prdata[`PVP_ST_SYNC] = q.synced;
                    n.prdata[`PVP_ST_CFGERR] = cfg_err;
                    n.prdata[`PVP_ST_PHASE_LO +: 2] = q.phase;
                end
                default: begin
                    n.prdata = 32'h0000_0000;
                    n.pslverr = 1'b1;
                end
            endcase
            if ((a[ADDR_W-1:5] != '0) || (a[1:0] != 2'b00)) begin
                n.prdata = 32'h0000_0000;
                n.pslverr = 1'b1;
            end
        end
        if (rd_acc && !q.pslverr && (a[4:0] == 5'(`PVP_OFS_RXDATA))) begin
            n.rx_valid = 1'b0;
        end
        if (wr_acc && !q.pslverr) begin
            case (a[4:0])
                5'(`PVP_OFS_CTRL): n.ctrl = pwdata[15:0];
                5'(`PVP_OFS_DELAY): n.delay = pwdata[15:0];
                5'(`PVP_OFS_COUNT): n.count = pwdata[15:0];
                5'(`PVP_OFS_LINE_LEN): n.line_len = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
                5'(`PVP_OFS_FRAME_LINES): n.frame_lines = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
                5'(`PVP_OFS_TXDATA): begin
                    n.txd = pwdata[15:0];
                    n.tx_full = 1'b1;
                end
                5'(`PVP_OFS_STATUS): begin
                    if (pwdata[`PVP_ST_OVR]) begin
                        n.overrun = 1'b0;
                    end
                    if (pwdata[`PVP_ST_UND]) begin
                        n.underrun = 1'b0;
                    end
                end
                default: n.ctrl = q.ctrl;
            endcase
        end

        // Hardware sets after software clears, so a same-cycle event is kept
        if (push) begin
            if (q.rx_valid && !(rd_acc && (a[4:0] == 5'(`PVP_OFS_RXDATA)))) begin
                ovr_ev = 1'b1;
            end
            n.rxd = push_d;
            n.rx_valid = 1'b1;
        end
        if (ovr_ev) begin
            n.overrun = 1'b1;
        end
        if (und_ev) begin
            n.underrun = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            q <= '0;
            q.ctrl <= `PVP_RST_CTRL;
            q.delay <= `PVP_RST_DELAY;
            q.count <= `PVP_RST_COUNT;
            q.line_len <= `PVP_RST_LINE_LEN;
            q.frame_lines <= `PVP_RST_FRAME_LINES;
            q.phase <= PVP_PH_IDLE;
            q.fld <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = q.prdata;
    assign pslverr = q.pslverr && psel && penable;
    assign pready = psel && penable;

    always_comb begin
        pins.data_out = q.dout;
        pins.fs_out = q.fs_drv;
        pins.data_oe = (en && !cfg_err && out_dir) ? wmask : 16'h0000;
        pins.fs_oe = 3'h0;
        if (en && !cfg_err && !itu) begin
            case (gpm)
                PVP_GP_CAP: pins.fs_oe = 3'b011;
                PVP_GP_OUT: pins.fs_oe = (nfs == 2'h3) ? 3'b111 : ((nfs == 2'h2) ? 3'b011 : 3'b001);
                default: pins.fs_oe = 3'h0;
            endcase
        end
    end

endmodule : pvp_port

// ### pvp_port_chk.sv
/*
 * Checker of pvp_port pin drive and APB answers, bound to the port.
 * Assumes software writes CTRL with legal values only.
 */
`include "pvp_cfg.svh"
module pvp_port_chk import pvp_pkg::*; #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Port pins
    input wire logic port_clock,
    input wire logic [2:0] frame_sync_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire pvp_pins_s pins
);
    // Shadow of CTRL, rebuilt from bus writes since the checker cannot see it
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic ctl_wr;
    logic gp;
    logic [1:0] md;
    logic [15:0] wmask;
    logic [2:0] fsmask;
    always_comb begin
        ctl_wr = psel && penable && pwrite && paddr == ADDR_W'(`PVP_OFS_CTRL);
        ctl_d = ctl_wr ? pwdata[15:0] : ctl_q;
        gp = ctl_q[0] && !ctl_q[1];
        md = ctl_q[3:2];
        wmask = 16'hFFFF >> (4'hF - ctl_q[11:8]);
        fsmask = ctl_q[13] ? (ctl_q[12] ? 3'h7 : 3'h3) : 3'h1;
    end
    always_ff @(posedge ref_clk) begin
        ctl_q <= rstn ? ctl_d : `PVP_RST_CTRL;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    chk_in_all_in: assert property (gp && md == 2'h0 |-> pins.fs_oe == 3'h0 && pins.data_oe == 16'h0)
        else $error("input submode drives a pin");
    chk_cap_syncs: assert property (gp && md == 2'h1 |-> pins.fs_oe[1:0] == 2'h3 && pins.data_oe == 16'h0)
        else $error("frame capture drive wrong");
    chk_out_width: assert property (gp && md == 2'h2 |-> pins.data_oe == wmask)
        else $error("output data enables wrong");
    chk_out_syncs: assert property (gp && md == 2'h2 |-> pins.fs_oe == fsmask)
        else $error("output sync enables wrong");
    chk_oe_mask: assert property (pins.data_oe != 16'h0 |-> pins.data_oe == wmask)
        else $error("data enables not the width");
    chk_ctrl_drive: assert property (ctl_wr && pwdata[3:0] == 4'h9 |=> pins.fs_oe[0] && pins.data_oe[7:0] == 8'hFF)
        else $error("output mode not driving");
    chk_ready_acc: assert property (pready == (psel && penable))
        else $error("pready outside access");
    chk_err_unmapped: assert property (psel && penable && paddr[ADDR_W-1:5] != '0 |-> pslverr)
        else $error("unmapped access not refused");
endmodule : pvp_port_chk

bind pvp_port pvp_port_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) pvp_port_chk_i (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_clock(port_clock), .frame_sync_in(frame_sync_in), .data_in(data_in), .pins(pins)
);

// ### pvp_src_model.sv
/*
 * Converter or video source on the port pins, stepped by the bench.
 * Assumes one call of tick per port clock period.
 */
module pvp_src_model (
    // Pins toward the port
    output logic port_clock,
    output logic [2:0] frame_sync,
    output logic [15:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        port_clock = 1'b0;
        frame_sync = 3'h0;
        data = 16'h5A5A;
    end
    // Clock runs only inside frames; 80 ns phases span 4 system clocks
    task automatic tick(input logic fs1, input logic [15:0] d);
        frame_sync = {2'h0, fs1};
        data = d;
        #80;
        port_clock = 1'b1;
        #80;
        port_clock = 1'b0;
    endtask : tick
    // Released lines show inverted data so a stale value cannot pass
    task automatic rest();
        frame_sync = 3'h0;
        data = ~data;
    endtask : rest
endmodule : pvp_src_model

// ### tb.sv
/*
 * Bench of pvp_port: APB registers, general-purpose capture and drive,
 * 656 input submodes. Assumes pvp_src_model on the port pins.
 */
module tb import pvp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Reference FF 00 00 then status: A0 blank SAV, 80 active SAV, 90 EAV
    localparam logic [7:0] ITU_S [23] = '{8'hFF, 8'h00, 8'h00, 8'hA0, 8'h31, 8'h32, 8'hFF, 8'h00, 8'h00, 8'h80,
        8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h66, 8'h67, 8'h68, 8'h69};
    localparam logic [7:0] ITU_X [3] = '{8'h55, 8'h32, 8'h66};
    logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, port_clock, err_q, seen_hs;
    logic [2:0] frame_sync_in;
    logic [15:0] data_in;
    pvp_pins_s pins_w;
    int failures = 0, n_compared = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) seen_hs <= rstn && (seen_hs || pins_w.fs_out[0]);
    pvp_port #(.DATA_W(16), .ADDR_W(8)) pvp_port_i (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_clock(port_clock),
        .frame_sync_in(frame_sync_in), .data_in(data_in), .pins(pins_w)
    );
    pvp_src_model pvp_src_model_i (.port_clock(port_clock), .frame_sync(frame_sync_in), .data(data_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t: got %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // One APB transfer; read data lands in rd, error flag in err_q
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            complete_run();
        end
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic do_reset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask : do_reset
    // Port clocks start 3 ns off the system edge to keep sampling order-free
    task automatic run(input int n, input logic [15:0] base);
        #3;
        for (int i = 0; i < n; i++) begin
            pvp_src_model_i.tick(i == 0, base + 16'(i));
        end
        pvp_src_model_i.rest();
    endtask : run
    task automatic gp_case(input logic [15:0] ctl, input int d, input int c, input logic [15:0] base,
            input logic [31:0] e, input logic [31:0] st);
        apb(8'h04, 1'b1, 32'(d));
        apb(8'h08, 1'b1, 32'(c));
        apb(8'h00, 1'b1, {16'h0, ctl});
        run(d + c + 3, base);
        apb(8'h0C, 1'b0, 32'h0);
        check(rd & 32'h3, st);
        apb(8'h10, 1'b0, 32'h0);
        check(rd, e);
        apb(8'h0C, 1'b1, 32'hA);
        apb(8'h00, 1'b1, 32'h0);
    endtask : gp_case
    initial begin
        do_reset();
        apb(8'h08, 1'b0, 32'h0);
        check(rd, 32'h1);
        apb(8'h02, 1'b1, 32'h1);
        check(32'(err_q), 32'h1);
        apb(8'h20, 1'b0, 32'h0);
        check({rd[30:0], err_q}, 32'h1);
        apb(8'h00, 1'b0, 32'h0);
        check(rd, 32'h1F00);
        gp_case(16'h0901, 2, 3, 16'hA5C0, 32'h01C5, 32'h3);
        gp_case(16'h0701, 0, 1, 16'h12F0, 32'h00F1, 32'h1);
        do_reset();
        apb(8'h00, 1'b1, 32'h3F09);
        apb(8'h14, 1'b1, 32'hBEEF);
        run(20, 16'h0);
        check({pins_w.data_oe, pins_w.data_out}, 32'hFFFF_BEEF);
        check(32'(pins_w.fs_oe), 32'h7);
        do_reset();
        apb(8'h00, 1'b1, 32'h0F05);
        run(20, 16'h0);
        check({15'h0, seen_hs, pins_w.data_oe}, 32'h1_0000);
        for (int m = 0; m < 3; m++) begin
            do_reset();
            apb(8'h00, 1'b1, 32'h0703 | 32'(m << 4));
            #3;
            foreach (ITU_S[i]) begin
                pvp_src_model_i.tick(1'b0, {8'h00, ITU_S[i]});
            end
            pvp_src_model_i.rest();
            apb(8'h0C, 1'b0, 32'h0);
            check(rd & 32'hA0, 32'h80);
            apb(8'h10, 1'b0, 32'h0);
            check(rd, {24'h0, ITU_X[m]});
        end
        complete_run();
    end
endmodule : tb
